/* hdl/asc_regs.svh */
// Constants for the converter standby controller
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
`define ASC_SETTLE_PERIODS   2'h3
`define ASC_TEST_CHANNEL     3'h6
`define ASC_OFFSET_RESET     24'h800000
`define ASC_CMD_DATA_RD      2'h1
`define ASC_CMD_OFFS_RD      2'h2
`define ASC_CMD_OFFS_WR      2'h3
`endif

/* hdl/asc_pkg.sv */
// Types for the converter standby controller
package asc_pkg;
  typedef enum logic [1:0] {
    ASC_CMD_NONE,
    ASC_CMD_DATA_READ,
    ASC_CMD_OFFSET_READ,
    ASC_CMD_OFFSET_WRITE
  } asc_cmd_t;
  typedef enum {
    ASC_PORT_IDLE,
    ASC_PORT_BUSY
  } asc_port_t;
  typedef struct packed {
    logic     valid;
    asc_cmd_t cmd;
    logic [23:0] wdata;
  } asc_req_t;
  typedef struct packed {
    logic        valid;
    logic [23:0] rdata;
  } asc_rsp_t;
endpackage : asc_pkg

/* hdl/asc_settle_timer.sv */
// Settling timer: counts output periods after standby release
module asc_settle_timer
  import asc_pkg::*;
#(
  parameter int unsigned PERIODS = 3
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_hold,
  input  wire logic i_period_tick,
  output logic      o_done
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       run_reg;
  logic       run_next;
  logic       done_next;
  logic       done_reg;
  // Next state of the period counter
  always_comb begin
    cnt_next  = cnt_reg;
    run_next  = run_reg;
    done_next = 1'b0;
    if (i_hold) begin
      // Filter held in reset, nothing counts
      cnt_next = 2'h0;
      run_next = 1'b0;
    end else if (i_start) begin
      cnt_next = 2'h0;
      run_next = 1'b1;
    end else if (run_reg && i_period_tick) begin
      if (cnt_reg == 2'(PERIODS - 1)) begin
        run_next  = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end
  // Register stage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_reg  <= 2'h0;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      run_reg  <= run_next;
      done_reg <= done_next;
    end
  end
  assign o_done = done_reg;
endmodule : asc_settle_timer

/* hdl/asc_standby_ctrl.sv */
// Standby control of the converter digital core
// Standby entry
//   Standby is a level on i_standby_n, low means standby
//   Sampled on every edge, no filtering of short pulses
//   Modulator run output drops in the same cycle
//   Request ready drops in the same cycle, so nothing is taken
//   Serial port state falls back to idle on the next edge
//   Data-ready parks high on the next edge
//   Data word and offset coefficient are left untouched
//   A request that is forced through anyway is ignored
//
// Standby exit
//   Release is the first edge that sees the input high again
//   Settling timer restarts on that edge
//   Output-rate ticks come from the filter side, one per period
//   Filter words that arrive while settling are dropped
//   Reason: the filter history is stale until it refills
//   After the third tick the timer pulses done for one cycle
//   The word on the filter bus is then loaded, data-ready drops
//   Limitation: the filter word must be valid at that cycle
//   Reads during settling still return the kept data word
//
// Reset
//   Reset is treated like a standby that ends with reset
//   So a release from reset also waits out the settling time
//   Offset coefficient returns to its mid-scale default
//   Data word clears, data-ready parks high, port goes idle
//
// Requests
//   One request per cycle, taken on the edge that sees valid
//   Reads answer one cycle later with a one-cycle valid pulse
//   Offset writes give no answer and show up the next cycle
//   A data read clears data-ready unless a new word lands too
//   Trade-off: the set wins, so a fresh word is never missed
//   The port marks itself busy for the cycle after a request other than ASC_CMD_NONE
//
// Side paths
//   Master clock is a plain wire copy of the oscillator
//   No gating anywhere on that path, so standby cannot stop it
//   Hazard: any logic added on this path would glitch the output
//   Test channel code shorts both modulator inputs together
//   Decode is combinational, it follows the channel input directly
//   Offset coefficient feeds the conversion path as stored
//   Writes take effect on the next conversion after the write
//
// Limits
//   Settling counter is two bits, enough for three periods
//   Only full 24-bit words move across the request interface
//   Channel codes other than the test code have no effect here
//   Selection of analog inputs sits outside this block
`include "asc_regs.svh"
module asc_standby_ctrl
  import asc_pkg::*;
#(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_standby_n,
  input  wire logic              i_osc_clock,
  input  wire logic              i_period_tick,
  input  wire logic [WIDTH-1:0]  i_filter_word,
  input  wire logic              i_filter_valid,
  input  wire logic [2:0]        i_channel,
  input  wire asc_req_t          i_req,
  output asc_rsp_t               o_rsp,
  output logic                   o_req_ready,
  output logic                   o_data_ready_n,
  output logic                   o_shorted_test_channel,
  output logic                   o_modulator_run,
  output logic                   o_port_expect_comm,
  output logic [WIDTH-1:0]       o_offset_coeff,
  output logic                   o_master_clock
);
  logic             stby_reg;       // Standby input seen last cycle
  logic             stby_next;
  logic             settle_reg;     // Waiting for filter to settle
  logic             settle_next;
  logic [WIDTH-1:0] data_reg;       // Conversion data, kept in standby
  logic [WIDTH-1:0] data_next;
  logic [WIDTH-1:0] offs_reg;       // Zero-scale coefficient
  logic [WIDTH-1:0] offs_next;
  // Data-ready flag, set on a new word, cleared by a read
  logic             rdy_n_reg;      // Data-ready, active low
  logic             rdy_n_next;
  asc_port_t        port_reg;       // Serial port state
  asc_port_t        port_next;
  asc_rsp_t         rsp_reg;
  asc_rsp_t         rsp_next;
  logic             in_standby;
  logic             release_edge;
  logic             settled;
  logic             new_word;
  logic             test_sel;

  assign in_standby   = ~i_standby_n;
  assign release_edge = i_standby_n & stby_reg;
  assign test_sel     = (i_channel == `ASC_TEST_CHANNEL);

  // Settling count restarts on release, held while in standby
  // Hold keeps the timer cleared for the whole standby, so a
  // half-finished count can never complete after a short release
  asc_settle_timer #(
    .PERIODS (`ASC_SETTLE_PERIODS)
  ) u_settle (
    .i_clock       (i_clock),
    .i_rst         (i_rst),
    .i_start       (release_edge),
    .i_hold        (in_standby),
    .i_period_tick (i_period_tick),
    .o_done        (settled)
  );

  // A word counts only once the filter has settled
  assign new_word = i_filter_valid & ~in_standby & ~settle_reg;

  // Next values for the core state
  always_comb begin
    stby_next   = in_standby;
    settle_next = settle_reg;
    data_next   = data_reg;
    offs_next   = offs_reg;
    // Data-ready holds unless an event below moves it
    rdy_n_next  = rdy_n_reg;
    port_next   = port_reg;
    rsp_next    = '0;
    if (release_edge) begin
      settle_next = 1'b1;
    end else if (settled) begin
      settle_next = 1'b0;
    end
    if (in_standby) begin
      // Port abandoned, data-ready parked high, no answers
      port_next   = ASC_PORT_IDLE;
      rdy_n_next  = 1'b1;
    end else begin
      // Settled word (or any valid word after settle) lands in data register
      if (settled || new_word) begin
        data_next   = i_filter_word;
        rdy_n_next  = 1'b0;
      end
      // One request a cycle while the port is live
      if (i_req.valid) begin
        port_next = ASC_PORT_BUSY;
        case (i_req.cmd)
          ASC_CMD_DATA_READ: begin
            rsp_next.valid = 1'b1;
            rsp_next.rdata = data_reg;
            // New word in same cycle wins over the read clear
            if (!(settled || new_word)) begin
              rdy_n_next  = 1'b1;
            end
          end
          ASC_CMD_OFFSET_READ: begin
            rsp_next.valid = 1'b1;
            rsp_next.rdata = offs_reg;
          end
          ASC_CMD_OFFSET_WRITE: begin
            offs_next = i_req.wdata;
          end
          default: begin
            port_next = ASC_PORT_IDLE;
          end
        endcase
      end else begin
        port_next = ASC_PORT_IDLE;
      end
    end
  end

  // Register stage; reset gives power-on defaults
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      // Reset counts as standby, so the first high input after
      // reset is a release and the filter settles before any word
      stby_reg   <= 1'b1;
      settle_reg <= 1'b0;
      data_reg   <= '0;
      offs_reg   <= WIDTH'(`ASC_OFFSET_RESET);
      rdy_n_reg  <= 1'b1;
      port_reg   <= ASC_PORT_IDLE;
      rsp_reg    <= '0;
    end else begin
      stby_reg   <= stby_next;
      settle_reg <= settle_next;
      data_reg   <= data_next;
      offs_reg   <= offs_next;
      rdy_n_reg  <= rdy_n_next;
      port_reg   <= port_next;
      rsp_reg    <= rsp_next;
    end
  end

  // Requests refused while in standby
  assign o_req_ready            = ~in_standby;
  assign o_rsp                  = rsp_reg;
  // Data-ready straight from its flip-flop, no decode glitches
  assign o_data_ready_n         = rdy_n_reg;
  // Both inputs to the same pin on the test code
  assign o_shorted_test_channel = test_sel;
  // Modulator stops while standby is low
  assign o_modulator_run        = ~in_standby;
  // Idle port waits for a communications write
  assign o_port_expect_comm     = (port_reg == ASC_PORT_IDLE);
  // Conversions use whatever offset is stored
  assign o_offset_coeff         = offs_reg;
  // Oscillator passes straight through; standby never gates it
  assign o_master_clock         = i_osc_clock;
endmodule : asc_standby_ctrl

/* testbench/asc_host_model.sv */
// Host model that raises requests toward the standby controller
module asc_host_model
  import asc_pkg::*;
(
  input  wire logic        i_go,
  input  wire logic        i_force,
  input  wire logic        i_standby_n,
  input  wire asc_cmd_t    i_cmd,
  input  wire logic [23:0] i_wdata,
  output asc_req_t         o_req
);
  // Host holds off during standby unless told to misbehave
  assign o_req = '{valid: i_go & (i_force | i_standby_n), cmd: i_cmd, wdata: i_wdata};
endmodule : asc_host_model

/* testbench/asc_standby_ctrl_sva.sv */
// Assertions for the standby controller ports
module asc_standby_ctrl_sva
  import asc_pkg::*;
#(parameter int unsigned WIDTH = 24) (
  input wire logic             i_clock,
  input wire logic             i_rst,
  input wire logic             i_standby_n,
  input wire logic             i_osc_clock,
  input wire logic [2:0]       i_channel,
  input wire asc_req_t         i_req,
  input wire asc_rsp_t         o_rsp,
  input wire logic             o_req_ready,
  input wire logic             o_data_ready_n,
  input wire logic             o_shorted_test_channel,
  input wire logic             o_modulator_run,
  input wire logic             o_port_expect_comm,
  input wire logic [WIDTH-1:0] o_offset_coeff,
  input wire logic             o_master_clock
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Standby held a full cycle, so a late answer cannot fire
  a_ready_follow: assert property (o_req_ready == i_standby_n) else $error("ready wrong");
  a_ready_forced: assert property (!i_standby_n && $past(!i_standby_n) |-> o_data_ready_n) else $error("ready low");
  a_no_answer: assert property (!i_standby_n && $past(!i_standby_n) |-> !o_rsp.valid) else $error("answer");
  a_run_follow: assert property (o_modulator_run == i_standby_n) else $error("run wrong");
  a_port_idle: assert property (!i_standby_n |=> o_port_expect_comm) else $error("port busy");
  a_short_test: assert property (o_shorted_test_channel == (i_channel == 3'h6)) else $error("short");
  a_clock_pass: assert property (o_master_clock == i_osc_clock) else $error("mclk");
  a_read_answer: assert property (i_req.valid && i_standby_n && (i_req.cmd == ASC_CMD_DATA_READ ||
    i_req.cmd == ASC_CMD_OFFSET_READ) |=> o_rsp.valid) else $error("no answer");
  a_offs_write: assert property (i_req.valid && i_standby_n && i_req.cmd == ASC_CMD_OFFSET_WRITE
    |=> o_offset_coeff == $past(i_req.wdata)) else $error("offset");
  a_offs_keep: assert property (!i_standby_n |=> $stable(o_offset_coeff)) else $error("offset lost");
  c_release: cover property ($rose(i_standby_n));
  c_answer: cover property (o_rsp.valid);
  c_new_word: cover property ($fell(o_data_ready_n));
endmodule : asc_standby_ctrl_sva
bind asc_standby_ctrl asc_standby_ctrl_sva #(.WIDTH(WIDTH)) u_sva (.i_clock, .i_rst, .i_standby_n,
  .i_osc_clock, .i_channel, .i_req, .o_rsp, .o_req_ready, .o_data_ready_n, .o_shorted_test_channel,
  .o_modulator_run, .o_port_expect_comm, .o_offset_coeff, .o_master_clock);

/* testbench/tb_top.sv */
// Self-checking bench for the standby controller
module tb_top import asc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, osc = 1'b0, rst, sb_n, tick, fvalid, go, frc, data_ready_n, short, run, comm, mclk, rdy, cm;
  logic [23:0] fword, wdata, offs, w, o;
  logic [2:0] chan;
  logic [31:0] seed = 32'h9F3CAC5D;
  asc_cmd_t cmd;
  asc_req_t req;
  asc_rsp_t rsp, r;
  int mismatches = 0, checked = 0;
  asc_host_model host (.i_go(go), .i_force(frc), .i_standby_n(sb_n), .i_cmd(cmd), .i_wdata(wdata), .o_req(req));
  asc_standby_ctrl dut (.i_clock(clk), .i_rst(rst), .i_standby_n(sb_n), .i_osc_clock(osc),
    .i_period_tick(tick), .i_filter_word(fword), .i_filter_valid(fvalid), .i_channel(chan), .i_req(req),
    .o_rsp(rsp), .o_req_ready(rdy), .o_data_ready_n(data_ready_n), .o_shorted_test_channel(short),
    .o_modulator_run(run), .o_port_expect_comm(comm), .o_offset_coeff(offs), .o_master_clock(mclk));
  initial forever #2 clk = ~clk;
  // Oscillator offset by half a ns so it never moves at a sample point
  initial begin #0.5; forever #3 osc = ~osc; end
  function logic [31:0] xs();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction : xs
  task finish_test();
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin mismatches++; $display("FAIL %s expected %h seen %h", n, e, g); end
  endtask : chk
  // Inputs other than the clocks move 1 ns after the rising edge
  task cyc(input int n); repeat (n) @(posedge clk); #1; endtask : cyc
  task xfer(input asc_cmd_t c, input logic [23:0] d, input logic f);
    cmd = c; wdata = d; frc = f; go = 1'b1; cyc(1); r = rsp; cm = comm; go = 1'b0; cyc(1);
  endtask : xfer
  initial begin
    rst = 1; sb_n = 0; tick = 0; fword = 0; fvalid = 0; chan = 0; go = 0; frc = 0; wdata = 0; cmd = ASC_CMD_NONE;
    cyc(2); rst = 0;
    chk("ready_rst", 24'h1, 24'(data_ready_n));
    chk("offs_rst", 24'h800000, offs);
    w = 24'(xs()); fword = w; sb_n = 1; // Release, then three period ticks
    repeat (3) begin cyc(3); tick = 1; cyc(1); tick = 0; end
    chk("ready_early", 24'h1, 24'(data_ready_n));
    cyc(2); chk("ready_settled", 24'h0, 24'(data_ready_n));
    xfer(ASC_CMD_DATA_READ, 24'h0, 0); chk("rd_data", w, r.rdata);
    chk("rd_valid", 24'h1, 24'(r.valid));
    chk("comm_busy", 24'h0, 24'(cm));
    chk("ready_read", 24'h1, 24'(data_ready_n));
    chk("req_ready_run", 24'h1, 24'(rdy));
    chk("run_live", 24'h1, 24'(run));
    repeat (4) begin o = 24'(xs()); xfer(ASC_CMD_OFFSET_WRITE, o, 0); xfer(ASC_CMD_OFFSET_READ, 24'h0, 0);
      chk("offs_rd", o, r.rdata); end
    w = 24'(xs()); fword = w; fvalid = 1; cyc(1); fvalid = 0; cyc(2);
    chk("ready_word", 24'h0, 24'(data_ready_n));
    sb_n = 0; cyc(2);
    chk("ready_sb", 24'h1, 24'(data_ready_n));
    chk("comm_sb", 24'h1, 24'(comm));
    chk("req_ready_sb", 24'h0, 24'(rdy));
    chk("run_sb", 24'h0, 24'(run));
    chk("mclk_sb", 24'(osc), 24'(mclk));
    xfer(ASC_CMD_OFFSET_WRITE, ~o, 1); xfer(ASC_CMD_DATA_READ, 24'h0, 1); chk("rsp_sb", 24'h0, 24'(r.valid));
    chk("comm_forced", 24'h1, 24'(cm));
    chk("offs_sb", o, offs);
    sb_n = 1; cyc(1); xfer(ASC_CMD_DATA_READ, 24'h0, 0); chk("rd_kept", w, r.rdata);
    // Word offered while settling must be dropped
    fword = ~w; fvalid = 1; cyc(1); fvalid = 0; chk("ready_drop", 24'h1, 24'(data_ready_n));
    repeat (3) begin cyc(3); tick = 1; cyc(1); tick = 0; end
    chk("ready_resettle", 24'h1, 24'(data_ready_n));
    cyc(2); chk("ready_resettled", 24'h0, 24'(data_ready_n));
    xfer(ASC_CMD_DATA_READ, 24'h0, 0); chk("rd_new", ~w, r.rdata);
    for (int i = 0; i < 8; i++) begin chan = 3'(i); cyc(1); chk("short", 24'(i == 6), 24'(short)); end
    finish_test();
  end
  initial begin #20000; mismatches++; finish_test(); end
endmodule : tb_top
